// *** verilog/sync_serial_frame_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sync_serial_regs.svh"
module sync_serial_frame_sequencer
   import sync_serial_pkg::*;
#(
   parameter int HALF_DIV = `HALF_DIV_DEFAULT
) (
   // system clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // link clock
   input wire logic link_clk_i,
   // static configuration
   input wire logic enable_i,
   input wire logic master_i,
   input wire logic clock_polarity_i,
   input wire logic clock_phase_i,
   input wire logic control_word_mode_i,
   input wire logic [3:0] word_len_m1_i,
   // transmit word
   input wire logic tx_valid_i,
   input wire logic [`WORD_W-1:0] tx_data_i,
   output logic tx_ready_o,
   // receive word
   output logic rx_valid_o,
   output logic [`WORD_W-1:0] rx_data_o,
   // status
   output logic busy_o,
   output logic rx_lost_o,
   // serial clock pin
   input wire logic serial_clock_pin_i,
   output logic serial_clock_pin_o,
   output logic serial_clock_pin_oe_o,
   // frame select pin
   input wire logic frame_select_n_i,
   output logic frame_select_n_o,
   output logic frame_select_n_oe_o,
   // data pins
   output logic serial_out_o,
   output logic serial_out_oe_o,
   input wire logic serial_in_i
);

   // ************************************************************
   // helpers
   // ************************************************************

   // left-align a word so its MSB sits in the top bit
   function automatic logic [`WORD_W-1:0] load_word(input logic [`WORD_W-1:0] d, input logic uw,
                                                    input logic [3:0] len);
      if (uw) begin
         load_word = {d[7:0], 8'h00};
      end else begin
         load_word = d << (4'hf - len);
      end
   endfunction

   // keep only the bits of the programmed length
   function automatic logic [`WORD_W-1:0] rx_word(input logic [`WORD_W-1:0] r, input logic [3:0] len);
      rx_word = r & (16'hffff >> (4'hf - len));
   endfunction

   localparam logic [7:0] HALF_LAST = 8'(HALF_DIV - 1);
   localparam logic [4:0] REPLY_FIRST = `CMD_BITS + `CMD_WAIT_EDGES;
   localparam logic [1:0] TAIL_LAST = `TAIL_HALVES - 2'h1;

   // ************************************************************
   // declarations
   // ************************************************************

   link_state_t lr;
   link_state_t ln;
   sys_state_t sr;
   sys_state_t sn;
   logic [`CFG_W-1:0] cfg_s;
   logic [2:0] pin_s;
   logic [1:0] back_s;
   logic tx_load;
   logic tx_busy;
   logic pend_valid;
   logic [`WORD_W-1:0] pend_data;
   logic take_now;
   logic rx_busy;
   logic rx_dst_valid;
   logic [`WORD_W-1:0] rx_dst_data;
   logic cfg_en;
   logic cfg_master;
   logic cfg_uw;
   logic cmd_phase;
   logic idle_pol;
   logic pha;
   logic [3:0] word_len;
   logic [4:0] last_edge;
   logic half_done;
   logic edge_ev;
   logic cap_ev;

   // ************************************************************
   // crossings
   // ************************************************************

   // configuration is static while the port is enabled
   bit_sync #(.W(`CFG_W), .RST_VAL(`CFG_RST)) cfg_sync (
      .clk_i(link_clk_i),
      .arst_n_i(arst_n_i),
      .d_i({enable_i, master_i, clock_polarity_i, clock_phase_i, control_word_mode_i, word_len_m1_i}),
      .q_o(cfg_s)
   ); // RULE25

   // order: clock, select, data in
   bit_sync #(.W(3), .RST_VAL(`PIN_SYNC_RST)) pin_sync (
      .clk_i(link_clk_i),
      .arst_n_i(arst_n_i),
      .d_i({serial_clock_pin_i, frame_select_n_i, serial_in_i}),
      .q_o(pin_s)
   );

   bit_sync #(.W(2), .RST_VAL(2'h0)) back_sync (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .d_i({lr.lost_tgl, lr.busy}),
      .q_o(back_s)
   );

   word_cross #(.W(`WORD_W)) tx_cross (
      .src_clk_i(clk_i),
      .dst_clk_i(link_clk_i),
      .arst_n_i(arst_n_i),
      .src_load_i(tx_load),
      .src_data_i(tx_data_i),
      .src_busy_o(tx_busy),
      .dst_take_i(take_now),
      .dst_valid_o(pend_valid),
      .dst_data_o(pend_data)
   );

   word_cross #(.W(`WORD_W)) rx_cross (
      .src_clk_i(link_clk_i),
      .dst_clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .src_load_i(lr.push),
      .src_data_i(lr.push_data),
      .src_busy_o(rx_busy),
      .dst_take_i(rx_dst_valid),
      .dst_valid_o(rx_dst_valid),
      .dst_data_o(rx_dst_data)
   );

   // ************************************************************
   // configuration decode
   // ************************************************************

   assign cfg_en = cfg_s[`CFG_EN];
   assign cfg_master = cfg_s[`CFG_MASTER];
   assign cfg_uw = cfg_s[`CFG_UW];
   assign cmd_phase = cfg_uw & cfg_master;
   assign idle_pol = cfg_s[`CFG_POL] & ~cfg_uw; // RULE2
   assign pha = cfg_s[`CFG_PHA] & ~cfg_uw;
   assign word_len = (cfg_s[`CFG_LEN_LSB+:4] < `MIN_LEN_M1) ? `MIN_LEN_M1 : cfg_s[`CFG_LEN_LSB+:4]; // RULE23
   assign last_edge = cmd_phase ? (REPLY_FIRST + {1'b0, word_len}) : {1'b0, word_len}; // RULE11

   // ************************************************************
   // link sequencer
   // ************************************************************

   always_comb begin
      ln = lr;
      take_now = 1'b0;
      ln.push = 1'b0;
      ln.sclk_prev = pin_s[2];
      ln.fs_prev = pin_s[1];
      ln.sclk_oe = cfg_master; // RULE3
      ln.fs_oe = cfg_master;
      half_done = (lr.half_cnt == HALF_LAST);
      ln.half_cnt = half_done ? 8'h00 : lr.half_cnt + 8'h01;
      edge_ev = 1'b0;
      cap_ev = 1'b0;
      ln.lost_tgl = lr.lost_tgl ^ (lr.push & rx_busy);
      case (lr.state)
         ST_IDLE: begin
            ln.half_cnt = 8'h00;
            ln.fs_n = 1'b1; // RULE1
            ln.tx = 1'b0; // RULE1
            ln.tx_oe = cfg_master;
            ln.sclk = idle_pol; // RULE2
            ln.edge_cnt = 5'h00;
            ln.chain = 1'b0;
            ln.busy = 1'b0;
            if (cfg_en && cfg_master && pend_valid) begin
               take_now = 1'b1;
               ln.tx_sh = load_word(pend_data, cfg_uw, word_len);
               ln.fs_n = 1'b0; // RULE4
               ln.tx_oe = 1'b1; // RULE4
               ln.busy = 1'b1;
               if (cfg_uw) begin
                  ln.tx = ln.tx_sh[`WORD_W-1]; // RULE13
                  ln.lead = 1'b1;
                  ln.state = ST_SHIFT;
               end else begin
                  ln.state = ST_LEAD;
               end
            end else if (cfg_en && !cfg_master && lr.fs_prev && !pin_s[1]) begin
               // slave presents its MSB as soon as select falls
               take_now = pend_valid;
               ln.tx_sh = pend_valid ? load_word(pend_data, 1'b0, word_len) : '0;
               ln.tx = ln.tx_sh[`WORD_W-1]; // RULE6
               ln.tx_oe = 1'b1;
               ln.busy = 1'b1;
               ln.state = ST_SLAVE;
            end
         end
         ST_LEAD: begin
            if (half_done) begin
               ln.tx = lr.tx_sh[`WORD_W-1]; // RULE5 RULE6 RULE7
               ln.lead = ~pha;
               ln.state = ST_SHIFT;
               if (pha) begin
                  ln.sclk = ~lr.sclk; // RULE5 RULE7
               end
            end
         end
         ST_SHIFT: begin
            edge_ev = half_done;
            cap_ev = lr.lead ^ pha; // RULE24
            if (half_done) begin
               ln.sclk = ~lr.sclk;
               ln.lead = ~lr.lead;
            end
         end
         ST_TAIL: begin
            if (half_done) begin
               ln.sclk = idle_pol;
               ln.tail_cnt = lr.tail_cnt + 2'h1;
               if (lr.tail_cnt == TAIL_LAST) begin
                  ln.fs_n = 1'b1; // RULE8 RULE9 RULE17
                  ln.push = 1'b1; // RULE17
                  ln.push_data = rx_word(lr.rx_sh, word_len);
                  ln.busy = 1'b0;
                  ln.state = ST_IDLE;
               end
            end
         end
         ST_SLAVE: begin
            edge_ev = (pin_s[2] != lr.sclk_prev);
            cap_ev = (pin_s[2] != idle_pol) ^ pha; // RULE21 RULE24
            if (pin_s[1]) begin
               edge_ev = 1'b0;
               ln.tx = 1'b0;
               ln.tx_oe = 1'b0;
               ln.busy = 1'b0;
               ln.chain = 1'b0;
               ln.state = ST_IDLE;
               if (lr.chain) begin
                  ln.push = 1'b1;
                  ln.push_data = rx_word(lr.rx_sh, word_len);
               end
            end
         end
         default: begin
            ln.state = ST_IDLE;
         end
      endcase

      // ************************************************************
      // common edge handling, master and slave
      // ************************************************************

      if (edge_ev) begin
         if (cap_ev) begin
            ln.edge_cnt = lr.edge_cnt + 5'h01;
            if (!cmd_phase || lr.edge_cnt >= REPLY_FIRST) begin
               ln.rx_sh = {lr.rx_sh[`WORD_W-2:0], pin_s[0]}; // RULE12 RULE16
            end
            if (!cmd_phase || lr.edge_cnt < `CMD_BITS) begin
               ln.tx_sh = {lr.tx_sh[`WORD_W-2:0], 1'b0}; // RULE14 RULE23
            end
            if (lr.edge_cnt == last_edge) begin
               ln.edge_cnt = 5'h00;
               if (!cfg_master || (cfg_en && pend_valid && (cfg_uw || pha))) begin
                  ln.chain = 1'b1; // RULE10 RULE19
               end else begin
                  ln.tail_cnt = 2'h0;
                  ln.state = ST_TAIL; // RULE8 RULE9
               end
            end
         end else if (lr.chain) begin
            // next word starts on the drive edge right after the last capture
            ln.chain = 1'b0;
            ln.push = 1'b1; // RULE20
            ln.push_data = rx_word(lr.rx_sh, word_len);
            take_now = pend_valid;
            ln.tx_sh = pend_valid ? load_word(pend_data, cmd_phase, word_len) : '0;
            ln.tx = ln.tx_sh[`WORD_W-1]; // RULE19
         end else begin
            ln.tx = lr.tx_sh[`WORD_W-1]; // RULE5 RULE6 RULE7 RULE14
         end
      end
   end

   always_ff @(posedge link_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lr <= '0;
         lr.fs_n <= 1'b1;
         lr.fs_prev <= 1'b1;
      end else begin
         lr <= ln;
      end
   end

   // ************************************************************
   // system side
   // ************************************************************

   always_comb begin
      sn = sr;
      tx_load = sr.tx_ready & tx_valid_i;
      sn.tx_ready = ~tx_busy & ~tx_load;
      sn.rx_valid = rx_dst_valid;
      if (rx_dst_valid) begin
         sn.rx_data = rx_dst_data;
      end
      sn.busy = back_s[0];
      sn.lost_prev = back_s[1];
      sn.lost = back_s[1] ^ sr.lost_prev;
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sr <= '0;
      end else begin
         sr <= sn;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************

   assign tx_ready_o = sr.tx_ready;
   assign rx_valid_o = sr.rx_valid;
   assign rx_data_o = sr.rx_data;
   assign busy_o = sr.busy;
   assign rx_lost_o = sr.lost;
   assign serial_clock_pin_o = lr.sclk;
   assign serial_clock_pin_oe_o = lr.sclk_oe;
   assign frame_select_n_o = lr.fs_n;
   assign frame_select_n_oe_o = lr.fs_oe;
   assign serial_out_o = lr.tx;
   assign serial_out_oe_o = lr.tx_oe;

endmodule
`default_nettype wire

// *** verilog/sync_serial_regs.svh ***
// Operation
// RULE1 - while idle, frame select is held high and serial output is driven low
// RULE2 - idle clock level follows polarity; it is low in control-word mode
// RULE3 - idle master enables the clock pad; idle slave disables it
// RULE4 - enabled master with a queued word lowers frame select and enables serial output
// RULE5 - polarity 0, phase 1: data driven with first rising edge, falling capture
// RULE6 - polarity 1, phase 0: slave data at select fall, master half period later
// RULE7 - polarity 1, phase 1: data driven with first falling edge, rising capture
// RULE8 - single word: select rises one clock period after the last capture
// RULE9 - phase 0 back-to-back words: select pulses high between words
// RULE10 - phase 1 back-to-back words: select stays low, ends like a single word
// RULE11 - control-word frame: 8-bit command then 4 to 16 bit reply
// RULE12 - no incoming data is taken while the command byte shifts out
// RULE13 - a queued command starts the frame; its MSB appears at select fall
// RULE14 - select stays low all frame; command bits valid at each rising edge
// RULE15 - slave waits one clock after the command, then drives reply on falling edges
// RULE16 - control-word reply bits are sampled on rising clock edges
// RULE17 - single control-word frame: select rises one period after last bit, word pushed
// RULE18 - slave releases its data line after the reply or when select rises
// RULE19 - back-to-back control words: select low, next command follows reply LSB
// RULE20 - back-to-back replies leave the shifter on the falling edge after the LSB
// RULE21 - control-word slave samples the first bit on the first rising edge
// RULE22 - an external master gives select two periods setup and one period hold
// RULE23 - words go MSB first and are 4 to 16 bits long
// RULE24 - phase 0 captures on the first clock transition, phase 1 on the second
// RULE25 - configuration inputs are static and change only while disabled
`ifndef SYNC_SERIAL_REGS_SVH
`define SYNC_SERIAL_REGS_SVH
`define WORD_W 16
`define CFG_W 9
`define CFG_LEN_LSB 0
`define CFG_UW 4
`define CFG_PHA 5
`define CFG_POL 6
`define CFG_MASTER 7
`define CFG_EN 8
`define CFG_RST 9'h000
`define PIN_SYNC_RST 3'h2
`define MIN_LEN_M1 4'h3
`define CMD_BITS 5'h08
`define CMD_WAIT_EDGES 5'h01
`define TAIL_HALVES 2'h2
`define HALF_DIV_DEFAULT 4
`endif

// *** verilog/sync_serial_pkg.sv ***
`default_nettype none
`include "sync_serial_regs.svh"
package sync_serial_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_LEAD = 3'b001,
      ST_SHIFT = 3'b010,
      ST_TAIL = 3'b011,
      ST_SLAVE = 3'b100
   } link_phase_t;
   typedef struct packed {
      link_phase_t state;
      logic [7:0] half_cnt;
      logic [4:0] edge_cnt;
      logic [1:0] tail_cnt;
      logic lead;
      logic chain;
      logic [`WORD_W-1:0] tx_sh;
      logic [`WORD_W-1:0] rx_sh;
      logic sclk;
      logic sclk_oe;
      logic fs_n;
      logic fs_oe;
      logic tx;
      logic tx_oe;
      logic push;
      logic [`WORD_W-1:0] push_data;
      logic sclk_prev;
      logic fs_prev;
      logic busy;
      logic lost_tgl;
   } link_state_t;
   typedef struct packed {
      logic tx_ready;
      logic rx_valid;
      logic [`WORD_W-1:0] rx_data;
      logic busy;
      logic lost;
      logic lost_prev;
   } sys_state_t;
endpackage
`default_nettype wire

// *** verilog/bit_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // levels
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } sync_state_t;
   sync_state_t st_reg, st_next;
   always_comb begin
      st_next = st_reg;
      st_next.meta = d_i;
      st_next.sync = st_reg.meta;
   end
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_reg <= {RST_VAL, RST_VAL};
      end else begin
         st_reg <= st_next;
      end
   end
   assign q_o = st_reg.sync;
endmodule
`default_nettype wire

// *** verilog/word_cross.sv ***
`timescale 1ns/1ps
`default_nettype none
module word_cross #(
   parameter int W = 16
) (
   // clocks and reset
   input wire logic src_clk_i,
   input wire logic dst_clk_i,
   input wire logic arst_n_i,
   // source side
   input wire logic src_load_i,
   input wire logic [W-1:0] src_data_i,
   output logic src_busy_o,
   // destination side
   input wire logic dst_take_i,
   output logic dst_valid_o,
   output logic [W-1:0] dst_data_o
);
   typedef struct packed {
      logic req;
      logic [W-1:0] data;
   } src_state_t;
   typedef struct packed {
      logic ack;
   } dst_state_t;
   src_state_t s_reg, s_next;
   dst_state_t d_reg, d_next;
   logic ack_s;
   logic req_s;
   bit_sync #(.W(1), .RST_VAL(1'b0)) ack_sync (.clk_i(src_clk_i), .arst_n_i(arst_n_i), .d_i(d_reg.ack), .q_o(ack_s));
   bit_sync #(.W(1), .RST_VAL(1'b0)) req_sync (.clk_i(dst_clk_i), .arst_n_i(arst_n_i), .d_i(s_reg.req), .q_o(req_s));
   // data stays stable while a request toggle is outstanding
   always_comb begin
      s_next = s_reg;
      if (src_load_i && !src_busy_o) begin
         s_next.req = ~s_reg.req;
         s_next.data = src_data_i;
      end
   end
   always_comb begin
      d_next = d_reg;
      if (dst_take_i && dst_valid_o) begin
         d_next.ack = ~d_reg.ack;
      end
   end
   always_ff @(posedge src_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
   always_ff @(posedge dst_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         d_reg <= '0;
      end else begin
         d_reg <= d_next;
      end
   end
   assign src_busy_o = s_reg.req ^ ack_s;
   assign dst_valid_o = req_s ^ d_reg.ack;
   assign dst_data_o = s_reg.data;
endmodule
`default_nettype wire

// *** tb/frame_sequencer_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************
// link pin checks
// ****************
module frame_sequencer_assertions (
   // link clock and reset
   input wire logic link_clk_i,
   input wire logic arst_n_i,
   // configuration
   input wire logic enable_i,
   input wire logic master_i,
   input wire logic clock_polarity_i,
   input wire logic clock_phase_i,
   input wire logic control_word_mode_i,
   // pins
   input wire logic serial_clock_pin_o,
   input wire logic serial_clock_pin_oe_o,
   input wire logic frame_select_n_o,
   input wire logic frame_select_n_oe_o,
   input wire logic serial_out_o,
   input wire logic serial_out_oe_o
);
   default clocking @(posedge link_clk_i); endclocking
   default disable iff (!arst_n_i);
   logic spi;
   logic idle3;
   assign spi = master_i && !control_word_mode_i;
   always_ff @(posedge link_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         idle3 <= 1'b0;
      end else begin
         idle3 <= frame_select_n_o && $past(frame_select_n_o) && $past(frame_select_n_o, 2);
      end
   end
   idle_out_low_a: assert property (master_i && idle3 |-> !serial_out_o)
      else $error("serial out not low while idle");
   idle_clk_level_a: assert property (enable_i && master_i && idle3 |->
      serial_clock_pin_o == (clock_polarity_i && !control_word_mode_i))
      else $error("idle clock level wrong");
   clk_pad_a: assert property (enable_i && idle3 |-> serial_clock_pin_oe_o == master_i)
      else $error("idle clock pad enable wrong");
   start_drive_a: assert property ($fell(frame_select_n_o) |-> serial_out_oe_o && frame_select_n_oe_o)
      else $error("frame start without pads driven");
   lead_quiet_a: assert property (spi && $fell(frame_select_n_o) |-> ##1 $stable(serial_clock_pin_o)[*3])
      else $error("clock moved within first half period");
   capture_hold_a: assert property (spi && !frame_select_n_o && $changed(serial_clock_pin_o) &&
      serial_clock_pin_o == (clock_phase_i ~^ clock_polarity_i) |-> $stable(serial_out_o))
      else $error("serial out changed on capture edge");
   cmd_rise_hold_a: assert property (master_i && control_word_mode_i && !frame_select_n_o &&
      $rose(serial_clock_pin_o) |-> $stable(serial_out_o))
      else $error("command bit changed on rising edge");
   cmd_frame_low_a: assert property (master_i && control_word_mode_i && $fell(frame_select_n_o) |->
      ##1 !frame_select_n_o[*8])
      else $error("select rose inside command");
   tail_idle_a: assert property (master_i && $rose(frame_select_n_o) |->
      serial_clock_pin_o == (clock_polarity_i && !control_word_mode_i) &&
      $past(serial_clock_pin_o, 3) == (clock_polarity_i && !control_word_mode_i))
      else $error("select rose before clock tail");
   cover property ($fell(frame_select_n_o) && control_word_mode_i);
   cover property ($rose(frame_select_n_o) && clock_phase_i);
   cover property ($fell(frame_select_n_o) && clock_polarity_i && !clock_phase_i);
endmodule
bind sync_serial_frame_sequencer frame_sequencer_assertions i_checker (.link_clk_i, .arst_n_i, .enable_i,
   .master_i, .clock_polarity_i, .clock_phase_i, .control_word_mode_i, .serial_clock_pin_o,
   .serial_clock_pin_oe_o, .frame_select_n_o, .frame_select_n_oe_o, .serial_out_o, .serial_out_oe_o);
`default_nettype wire

// *** tb/serial_slave_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// **********************
// off-chip slave device
// **********************
module serial_slave_model (
   // link pins
   input wire logic sclk_i,
   input wire logic fs_n_i,
   input wire logic mosi_i,
   output logic miso_o,
   // set-up
   input wire logic pol_i,
   input wire logic pha_i,
   input wire logic cw_i,
   input wire logic [4:0] len_i,
   input wire logic [15:0] reply_i,
   // captured bits
   output logic [15:0] got_o
);
   logic [15:0] sh = '0;
   logic drv = 1'b0;
   logic last = 1'b0;
   int edges = 0;
   int sent = 0;
   // released line shows the inverse of its last value
   assign miso_o = drv ? sh[15] : ~last;
   initial got_o = '0;
   task automatic reload();
      sh = reply_i << (16 - len_i);
      edges = 0;
      sent = 0;
   endtask
   always @(negedge fs_n_i) begin
      reload();
      drv = !pha_i && !cw_i;
      sent = drv;
   end
   always @(posedge fs_n_i) begin
      last = miso_o;
      drv = 1'b0;
   end
   always @(sclk_i) begin
      if (!fs_n_i && cw_i) begin
         if (sclk_i) begin
            edges++;
            if (edges <= 8) got_o = {got_o[14:0], mosi_i};
         end else if (edges >= 9 && sent < len_i) begin
            if (sent > 0) sh = sh << 1;
            drv = 1'b1;
            sent++;
         end else if (sent == len_i) begin
            last = miso_o;
            drv = 1'b0;
            reload();
         end
      end else if (!fs_n_i) begin
         if ((sclk_i != pol_i) != pha_i) begin
            got_o = {got_o[14:0], mosi_i};
            edges++;
            if (edges == len_i && pha_i) reload();
         end else begin
            if (sent > 0) sh = sh << 1;
            drv = 1'b1;
            sent = 1;
         end
      end
   end
endmodule
`default_nettype wire

// *** tb/sync_serial_frame_sequencer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sync_serial_regs.svh"
module sync_serial_frame_sequencer_tb;
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic arst_n = 1'b0;
   logic enable = 1'b0, master = 1'b1, pol = 1'b0, pha = 1'b0, cw = 1'b0, tx_valid = 1'b0;
   logic [3:0] len_m1 = 4'h7;
   logic [`WORD_W-1:0] tx_data = '0, reply = '0, rx_data, got;
   logic tx_ready, rx_valid, busy, rx_lost, sclk, sclk_oe, fs_n, fs_oe, sout, sout_oe, sin;
   logic [`WORD_W-1:0] rx_q[$];
   int miscompares = 0;
   int checks_done = 0;
   int fs_rises = 0;
   int lost_seen = 0;
   always #25 clk = ~clk;
   initial begin
      #7;
      forever #62.5 link_clk = ~link_clk;
   end
   sync_serial_frame_sequencer #(.HALF_DIV(4)) i_dut (.clk_i(clk), .arst_n_i(arst_n), .link_clk_i(link_clk),
      .enable_i(enable), .master_i(master), .clock_polarity_i(pol), .clock_phase_i(pha),
      .control_word_mode_i(cw), .word_len_m1_i(len_m1), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
      .tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_data_o(rx_data), .busy_o(busy), .rx_lost_o(rx_lost),
      .serial_clock_pin_i(1'b0), .serial_clock_pin_o(sclk), .serial_clock_pin_oe_o(sclk_oe),
      .frame_select_n_i(1'b1), .frame_select_n_o(fs_n), .frame_select_n_oe_o(fs_oe),
      .serial_out_o(sout), .serial_out_oe_o(sout_oe), .serial_in_i(sin));
   serial_slave_model i_slave (.sclk_i(sclk), .fs_n_i(fs_n), .mosi_i(sout), .miso_o(sin), .pol_i(pol),
      .pha_i(pha), .cw_i(cw), .len_i({1'b0, len_m1} + 5'h01), .reply_i(reply), .got_o(got));
   always @(negedge clk) if (rx_valid === 1'b1) rx_q.push_back(rx_data);
   always @(posedge fs_n) fs_rises++;
   always @(negedge clk) if (rx_lost !== 1'b0) lost_seen++;
   // ******************
   // shared procedures
   // ******************
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
      checks_done++;
      if (exp !== seen) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   // configuration only changes while the port is disabled
   task automatic setup(input logic m, p, h, c, input logic [3:0] l);
      @(posedge clk);
      #2 enable = 1'b0;
      repeat (4) @(posedge link_clk);
      @(posedge clk);
      #2 {master, pol, pha, cw, len_m1} = {m, p, h, c, l};
      repeat (4) @(posedge link_clk);
      @(posedge clk);
      #2 enable = 1'b1;
      repeat (4) @(posedge link_clk);
      #1;
   endtask
   task automatic send(input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk);
      #2 tx_data = d;
      tx_valid = 1'b1;
      while (tx_ready !== 1'b1 && n < 4000) begin
         @(negedge clk);
         n++;
      end
      @(posedge clk);
      #2 tx_valid = 1'b0;
   endtask
   task automatic expect_rx(input logic [15:0] exp);
      int n;
      n = 0;
      while (rx_q.size() == 0 && n < 4000) begin
         @(negedge clk);
         n++;
      end
      check("rx word", exp, rx_q.size() > 0 ? rx_q.pop_front() : 16'hxxxx);
   endtask
   task automatic conclude();
      if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // **********
   // scenarios
   // **********
   task automatic t_idle();
      for (int i = 0; i < 6; i++) begin
         setup(i[0], i[1], 1'b0, i[2], 4'h7);
         check("select idle", 16'h0001, 16'(fs_n));
         check("clock pad", 16'(master), 16'(sclk_oe));
         if (master) check("out idle", 16'h0000, 16'(sout));
         if (master) check("clock idle", 16'(pol & ~cw), 16'(sclk));
      end
   endtask
   task automatic t_word(input logic p, h, input logic [3:0] l, input logic [15:0] d, r);
      int f;
      logic [15:0] mask;
      mask = 16'hffff >> (4'hf - l);
      setup(1'b1, p, h, 1'b0, l);
      reply = r;
      f = fs_rises;
      send(d);
      repeat (20) @(negedge clk);
      check("busy", 16'h0001, 16'(busy));
      expect_rx(r & mask);
      check("slave got", d & mask, got & mask);
      check("select rises", 16'h0001, 16'(fs_rises - f));
   endtask
   task automatic t_pair(input logic h);
      int f;
      setup(1'b1, ~h, h, 1'b0, 4'h7);
      reply = 16'h00c6;
      f = fs_rises;
      send(16'h0039);
      send(16'h00a2);
      expect_rx(16'h00c6);
      expect_rx(16'h00c6);
      check("slave got", 16'h39a2, got);
      check("select rises", h ? 16'h0001 : 16'h0002, 16'(fs_rises - f));
   endtask
   task automatic t_cw(input logic [3:0] l, input logic two);
      int f;
      logic [15:0] exp;
      exp = 16'hb5e3 & (16'hffff >> (4'hf - l));
      setup(1'b1, 1'b0, 1'b0, 1'b1, l);
      reply = 16'hb5e3;
      f = fs_rises;
      send(16'h335c);
      if (two) send(16'h44e1);
      expect_rx(exp);
      if (two) expect_rx(exp);
      check("command", two ? 16'h00e1 : 16'h005c, got & 16'h00ff);
      check("select rises", 16'h0001, 16'(fs_rises - f));
      check("rx lost", 16'h0000, 16'(lost_seen));
   endtask
   initial begin
      repeat (10) @(posedge clk);
      #2 arst_n = 1'b1;
      repeat (4) @(posedge link_clk);
      t_idle();
      t_word(1'b0, 1'b1, 4'h3, 16'h000a, 16'hfff5);
      t_word(1'b1, 1'b0, 4'hf, 16'hc3a5, 16'h5a3c);
      t_word(1'b1, 1'b1, 4'h7, 16'h0096, 16'h1269);
      t_pair(1'b0);
      t_pair(1'b1);
      t_cw(4'h3, 1'b0);
      t_cw(4'hf, 1'b1);
      conclude();
   end
   initial begin
      #1500000;
      miscompares++;
      conclude();
   end
endmodule
`default_nettype wire
